/* verilog/mux_bus_pkg.sv */
// Constants, types and register map of the multiplexed expansion bus
package mux_bus_pkg;

    localparam logic [31:0] FEATURE_ADDR = 32'h12000000;
    localparam logic [31:0] DIR_LOW_ADDR = 32'h12C00000;
    localparam logic [31:0] DIR_HIGH_ADDR = 32'h12C00001;
    localparam logic [31:0] LEVEL_LOW_ADDR = 32'h12C00002;
    localparam logic [31:0] LEVEL_STROBE_ADDR = 32'h12C00003;
    localparam logic [31:0] WINDOW_ADDR = 32'h60C00000;
    localparam logic [31:0] BUS_ADDR_REG_ADDR = 32'h60C00001;
    localparam logic [31:0] SEQ_ADDR = 32'h60C00002;
    localparam logic [31:0] ALT_ADDR = 32'h70C00000;

    localparam int FEAT_IRQ_BIT = 1;
    localparam int FEAT_DMA_BIT = 2;
    localparam int FEAT_CLK_BIT = 3;

    // Bit positions inside the upper line registers (line 8 is bit 0)
    localparam int HI_LATCH = 0;
    localparam int HI_READ = 1;
    localparam int HI_WRITE = 2;
    localparam int HI_IRQ = 3;
    localparam int HI_DMA = 4;
    localparam int HI_CLK = 5;
    localparam int LINE_COUNT = 14;
    localparam int LOW_LINES = 8;
    localparam int HIGH_LINES = LINE_COUNT - LOW_LINES;

    localparam logic [7:0] FEATURE_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] LEVEL_LOW_RESET = 8'h00;
    localparam logic [7:0] LEVEL_STROBE_RESET = 8'h07;
    localparam logic [7:0] BUS_ADDR_RESET = 8'h00;

    localparam int CLK_PERIOD_PS = 4000;
    localparam int STROBE_NS = 55;
    localparam int ADDR_PHASE_NS = 20;
    localparam int HOLD_NS = 8;
    localparam logic [7:0] STROBE_CYCLES =
        8'((STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] ADDR_CYCLES =
        8'((ADDR_PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] HOLD_CYCLES =
        8'((HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    localparam longint unsigned CORE_HZ = 64'd250000000;
    localparam longint unsigned CLKOUT_HZ = 64'd14745600;
    // Phase step per core cycle; the output toggles on each accumulator carry
    localparam logic [31:0] PHASE_INC = 32'(((64'd2 * CLKOUT_HZ) << 32) / CORE_HZ);

    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_HOLD} bus_state_t;

    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [7:0] wdata;
    } host_req_t;

endpackage : mux_bus_pkg

/* verilog/strobe_line.sv */
// One strobe line: idle level from the level register, inverted while toggled
`timescale 1ns/100ps
module strobe_line
(
    input wire logic clk,
    input wire logic rst,
    input wire logic dir_out,
    input wire logic idle_level,
    input wire logic toggle,
    output logic pin_out,
    output logic pin_oe
);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end
        else
        begin
            pin_out <= idle_level ^ (toggle & dir_out);
            pin_oe <= dir_out;
        end
    end

    property p_input_untouched;
        @(posedge clk) disable iff (rst)
        !dir_out |=> !pin_oe && (pin_out == $past(idle_level));
    endproperty
    a_input_untouched: assert property (p_input_untouched)
        else $error("strobe line toggled while set as input");

endmodule : strobe_line

/* verilog/clk_out_gen.sv */
// Fractional divider making the expansion clock from the core clock
`timescale 1ns/100ps
module clk_out_gen
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    output logic clk_level
);

    logic [31:0] phase;
    logic [32:0] next_phase;

    assign next_phase = {1'b0, phase} + {1'b0, mux_bus_pkg::PHASE_INC};

    // Jitter of one core cycle is the price of a single clock domain
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            phase <= 32'h00000000;
            clk_level <= 1'b0;
        end
        else if (!enable)
        begin
            phase <= 32'h00000000;
            clk_level <= 1'b0;
        end
        else
        begin
            phase <= next_phase[31:0];
            if (next_phase[32])
                clk_level <= ~clk_level;
        end
    end

    property p_clk_gated;
        @(posedge clk) disable iff (rst)
        !enable |=> !clk_level;
    endproperty
    a_clk_gated: assert property (p_clk_gated)
        else $error("clock output ran while disabled");

endmodule : clk_out_gen

/* verilog/muxed_expansion_bus.sv */
// Multiplexed 8-bit address/data expansion bus controller on general lines
//
// Overview of operation
// - Data lines driven only where direction says output
// - Strobes set as inputs are never toggled
// - Latch line 8, read 9, write 10
// - Strobe idle level from level register bit
// - Strobe level bits reset to seven
// - Latch strobe asserted while address is driven
// - Window access gives one 14-cycle (56 ns) strobe
// - Alias window uses separate programmable strobe timing
// - Sequential window steps to next bus address
// - Eight-bit bus address register, 256 bytes
// - Clock on line 13 when enabled and output
// - Interrupt input on line 11 when enabled
// - DMA request on line 12 when enabled
// - Bus interrupt is a shared host interrupt
`timescale 1ns/100ps
module muxed_expansion_bus
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic HOST_REQ,
    input wire mux_bus_pkg::host_req_t HOST_CMD,
    input wire logic [7:0] ALT_CS_TIMING,
    output logic HOST_ACK,
    output logic [7:0] HOST_RDATA,
    output logic HOST_BUSY,
    input wire logic [13:0] LINE_IN,
    output logic [13:0] LINE_OUT,
    output logic [13:0] LINE_OE,
    output logic BUS_IRQ,
    output logic DMA_REQ
);

    logic [13:0] line_meta;
    logic [13:0] line_sync;
    logic [7:0] feature;
    logic [7:0] dir_low;
    logic [7:0] dir_high;
    logic [7:0] level_low;
    logic [7:0] level_strobe;
    logic [7:0] bus_addr;
    mux_bus_pkg::bus_state_t state;
    logic [7:0] cnt;
    logic [7:0] strobe_len;
    logic op_we;
    logic op_seq;
    logic [7:0] op_wdata;
    logic [7:0] data_out;
    logic [7:0] data_oe;
    logic [2:0] hi_out;
    logic [2:0] hi_oe;
    logic [2:0] strobe_out;
    logic [2:0] strobe_oe;
    logic clk_level;
    logic accept;
    logic is_window;
    logic is_alt;
    logic reg_write;
    logic [7:0] next_data_out;
    logic [7:0] next_data_oe;
    logic [7:0] reg_rdata;
    logic [7:0] data_run;

    assign accept = HOST_REQ && !HOST_BUSY;
    assign is_alt = HOST_CMD.addr == mux_bus_pkg::ALT_ADDR;
    assign is_window = HOST_CMD.addr == mux_bus_pkg::WINDOW_ADDR
        || HOST_CMD.addr == mux_bus_pkg::SEQ_ADDR || is_alt;
    assign reg_write = accept && HOST_CMD.we && !is_window;

    // Pins are asynchronous to the core; only the second stage is looked at
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            line_meta <= 14'h0000;
            line_sync <= 14'h0000;
        end
        else
        begin
            line_meta <= LINE_IN;
            line_sync <= line_meta;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            feature <= mux_bus_pkg::FEATURE_RESET;
            dir_low <= mux_bus_pkg::DIR_RESET;
            dir_high <= mux_bus_pkg::DIR_RESET;
            level_low <= mux_bus_pkg::LEVEL_LOW_RESET;
            level_strobe <= mux_bus_pkg::LEVEL_STROBE_RESET;
        end
        else if (reg_write)
        begin
            unique case (HOST_CMD.addr)
                mux_bus_pkg::FEATURE_ADDR: feature <= HOST_CMD.wdata;
                mux_bus_pkg::DIR_LOW_ADDR: dir_low <= HOST_CMD.wdata;
                mux_bus_pkg::DIR_HIGH_ADDR: dir_high <= HOST_CMD.wdata;
                mux_bus_pkg::LEVEL_LOW_ADDR: level_low <= HOST_CMD.wdata;
                mux_bus_pkg::LEVEL_STROBE_ADDR: level_strobe <= HOST_CMD.wdata;
                default: ;
            endcase
        end
    end

    // Only 8 address bits exist; wider addressing uses spare lines in software
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            bus_addr <= mux_bus_pkg::BUS_ADDR_RESET;
        else if (reg_write && HOST_CMD.addr == mux_bus_pkg::BUS_ADDR_REG_ADDR)
            bus_addr <= HOST_CMD.wdata;
        else if (state == mux_bus_pkg::ST_HOLD && cnt == 8'h00 && op_seq)
            bus_addr <= 8'(bus_addr + 8'h01);
    end

    // Bus cycle sequencer: address phase, strobe phase, short hold
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= mux_bus_pkg::ST_IDLE;
            cnt <= 8'h00;
            strobe_len <= mux_bus_pkg::STROBE_CYCLES;
            op_we <= 1'b0;
            op_seq <= 1'b0;
            op_wdata <= 8'h00;
        end
        else
        begin
            unique case (state)
                mux_bus_pkg::ST_IDLE:
                begin
                    if (accept && is_window)
                    begin
                        state <= mux_bus_pkg::ST_ADDR;
                        cnt <= 8'(mux_bus_pkg::ADDR_CYCLES - 8'h01);
                        op_we <= HOST_CMD.we;
                        op_seq <= HOST_CMD.addr == mux_bus_pkg::SEQ_ADDR;
                        op_wdata <= HOST_CMD.wdata;
                        if (!is_alt)
                            strobe_len <= mux_bus_pkg::STROBE_CYCLES;
                        else if (ALT_CS_TIMING == 8'h00)
                            strobe_len <= 8'h01;
                        else
                            strobe_len <= ALT_CS_TIMING;
                    end
                end
                mux_bus_pkg::ST_ADDR:
                begin
                    if (cnt == 8'h00)
                    begin
                        state <= mux_bus_pkg::ST_DATA;
                        cnt <= 8'(strobe_len - 8'h01);
                    end
                    else
                        cnt <= 8'(cnt - 8'h01);
                end
                mux_bus_pkg::ST_DATA:
                begin
                    if (cnt == 8'h00)
                    begin
                        state <= mux_bus_pkg::ST_HOLD;
                        cnt <= 8'(mux_bus_pkg::HOLD_CYCLES - 8'h01);
                    end
                    else
                        cnt <= 8'(cnt - 8'h01);
                end
                mux_bus_pkg::ST_HOLD:
                begin
                    if (cnt == 8'h00)
                        state <= mux_bus_pkg::ST_IDLE;
                    else
                        cnt <= 8'(cnt - 8'h01);
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            HOST_BUSY <= 1'b0;
        else if (accept && is_window)
            HOST_BUSY <= 1'b1;
        else if (state == mux_bus_pkg::ST_HOLD && cnt == 8'h00)
            HOST_BUSY <= 1'b0;
    end

    always_comb
    begin
        unique case (HOST_CMD.addr)
            mux_bus_pkg::FEATURE_ADDR: reg_rdata = feature;
            mux_bus_pkg::DIR_LOW_ADDR: reg_rdata = dir_low;
            mux_bus_pkg::DIR_HIGH_ADDR: reg_rdata = dir_high;
            mux_bus_pkg::LEVEL_LOW_ADDR: reg_rdata = line_sync[7:0];
            mux_bus_pkg::LEVEL_STROBE_ADDR: reg_rdata = {2'b00, line_sync[13:8]};
            mux_bus_pkg::BUS_ADDR_REG_ADDR: reg_rdata = bus_addr;
            default: reg_rdata = 8'h00;
        endcase
    end

    // Register accesses answer next cycle; bus reads answer at end of hold
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            HOST_ACK <= 1'b0;
            HOST_RDATA <= 8'h00;
        end
        else
        begin
            HOST_ACK <= 1'b0;
            if (accept && !is_window)
            begin
                HOST_ACK <= 1'b1;
                HOST_RDATA <= HOST_CMD.we ? 8'h00 : reg_rdata;
            end
            else if (state == mux_bus_pkg::ST_HOLD && cnt == 8'h00)
                HOST_ACK <= 1'b1;
            if (state == mux_bus_pkg::ST_DATA && cnt == 8'h00 && !op_we)
                HOST_RDATA <= line_sync[7:0];
        end
    end

    always_comb
    begin
        next_data_out = level_low;
        next_data_oe = dir_low;
        unique case (state)
            mux_bus_pkg::ST_IDLE: ;
            mux_bus_pkg::ST_ADDR: next_data_out = bus_addr;
            mux_bus_pkg::ST_DATA, mux_bus_pkg::ST_HOLD:
            begin
                if (op_we)
                    next_data_out = op_wdata;
                else
                    next_data_oe = 8'h00;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            data_out <= 8'h00;
            data_oe <= 8'h00;
        end
        else
        begin
            data_out <= next_data_out;
            data_oe <= next_data_oe & dir_low;
        end
    end

    // Latch strobe swaps to its other level once the address phase is over
    strobe_line u_latch
    (
        .clk(CORE_CLK),
        .rst(RST),
        .dir_out(dir_high[mux_bus_pkg::HI_LATCH]),
        .idle_level(level_strobe[mux_bus_pkg::HI_LATCH]),
        .toggle(state == mux_bus_pkg::ST_DATA || state == mux_bus_pkg::ST_HOLD),
        .pin_out(strobe_out[0]),
        .pin_oe(strobe_oe[0])
    );

    strobe_line u_read
    (
        .clk(CORE_CLK),
        .rst(RST),
        .dir_out(dir_high[mux_bus_pkg::HI_READ]),
        .idle_level(level_strobe[mux_bus_pkg::HI_READ]),
        .toggle(state == mux_bus_pkg::ST_DATA && !op_we),
        .pin_out(strobe_out[1]),
        .pin_oe(strobe_oe[1])
    );

    strobe_line u_write
    (
        .clk(CORE_CLK),
        .rst(RST),
        .dir_out(dir_high[mux_bus_pkg::HI_WRITE]),
        .idle_level(level_strobe[mux_bus_pkg::HI_WRITE]),
        .toggle(state == mux_bus_pkg::ST_DATA && op_we),
        .pin_out(strobe_out[2]),
        .pin_oe(strobe_oe[2])
    );

    clk_out_gen u_clk
    (
        .clk(CORE_CLK),
        .rst(RST),
        .enable(feature[mux_bus_pkg::FEAT_CLK_BIT] && dir_high[mux_bus_pkg::HI_CLK]),
        .clk_level(clk_level)
    );

    // Lines 11 to 13 act as plain lines except for the enabled clock
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            hi_out <= 3'b000;
            hi_oe <= 3'b000;
        end
        else
        begin
            hi_out[0] <= level_strobe[mux_bus_pkg::HI_IRQ];
            hi_out[1] <= level_strobe[mux_bus_pkg::HI_DMA];
            hi_out[2] <= feature[mux_bus_pkg::FEAT_CLK_BIT]
                ? clk_level : level_strobe[mux_bus_pkg::HI_CLK];
            hi_oe <= dir_high[mux_bus_pkg::HI_CLK:mux_bus_pkg::HI_IRQ];
        end
    end

    assign LINE_OUT = {hi_out, strobe_out, data_out};
    assign LINE_OE = {hi_oe, strobe_oe, data_oe};

    // Level sensitive request; the host side ORs it with its other sources
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            BUS_IRQ <= 1'b0;
            DMA_REQ <= 1'b0;
        end
        else
        begin
            BUS_IRQ <= feature[mux_bus_pkg::FEAT_IRQ_BIT]
                && line_sync[mux_bus_pkg::LOW_LINES + mux_bus_pkg::HI_IRQ];
            DMA_REQ <= feature[mux_bus_pkg::FEAT_DMA_BIT]
                && line_sync[mux_bus_pkg::LOW_LINES + mux_bus_pkg::HI_DMA];
        end
    end

    // Counts strobe-phase cycles so the width can be checked on exit
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            data_run <= 8'h00;
        else if (state == mux_bus_pkg::ST_IDLE)
            data_run <= 8'h00;
        else if (state == mux_bus_pkg::ST_DATA)
            data_run <= 8'(data_run + 8'h01);
    end

    property p_data_oe_dir;
        @(posedge CORE_CLK) disable iff (RST)
        ##1 ((LINE_OE[7:0] & ~$past(dir_low)) == 8'h00);
    endproperty
    a_data_oe_dir: assert property (p_data_oe_dir)
        else $error("data line driven against its direction bit");

    property p_strobe_width;
        @(posedge CORE_CLK) disable iff (RST)
        $rose(state == mux_bus_pkg::ST_HOLD) |-> data_run == strobe_len;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe phase length differs from programmed length");

    property p_primary_len;
        @(posedge CORE_CLK) disable iff (RST)
        $rose(state == mux_bus_pkg::ST_ADDR) && !$past(is_alt)
            |-> strobe_len == mux_bus_pkg::STROBE_CYCLES;
    endproperty
    a_primary_len: assert property (p_primary_len)
        else $error("primary window strobe is not 14 cycles");

    property p_addr_on_lines;
        @(posedge CORE_CLK) disable iff (RST)
        state == mux_bus_pkg::ST_ADDR && $past(state) == mux_bus_pkg::ST_ADDR
            |=> LINE_OUT[7:0] == $past(bus_addr)
            && LINE_OUT[8] == $past(level_strobe[mux_bus_pkg::HI_LATCH]);
    endproperty
    a_addr_on_lines: assert property (p_addr_on_lines)
        else $error("address phase without address and latch level");

    property p_seq_step;
        @(posedge CORE_CLK) disable iff (RST)
        $fell(HOST_BUSY) && $past(op_seq) && !$past(reg_write)
            |-> bus_addr == 8'($past(bus_addr) + 8'h01);
    endproperty
    a_seq_step: assert property (p_seq_step)
        else $error("sequential access did not advance the address");

    property p_cycle_ack;
        @(posedge CORE_CLK) disable iff (RST)
        $fell(HOST_BUSY) |-> HOST_ACK && state == mux_bus_pkg::ST_IDLE;
    endproperty
    a_cycle_ack: assert property (p_cycle_ack)
        else $error("bus cycle ended without an answer");

    property p_read_float;
        @(posedge CORE_CLK) disable iff (RST)
        state == mux_bus_pkg::ST_DATA && !op_we |=> LINE_OE[7:0] == 8'h00;
    endproperty
    a_read_float: assert property (p_read_float)
        else $error("data lines driven during a read strobe");

    property p_irq_gate;
        @(posedge CORE_CLK) disable iff (RST)
        BUS_IRQ |-> $past(feature[mux_bus_pkg::FEAT_IRQ_BIT]);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt passed while disabled");

    property p_dma_gate;
        @(posedge CORE_CLK) disable iff (RST)
        DMA_REQ |-> $past(feature[mux_bus_pkg::FEAT_DMA_BIT]);
    endproperty
    a_dma_gate: assert property (p_dma_gate)
        else $error("DMA request passed while disabled");

endmodule : muxed_expansion_bus

/* testbench/bus_periph.sv */
// Peripheral model on the far side of the multiplexed expansion bus
`timescale 1ns/100ps
module bus_periph
(
    input wire logic clk,
    input wire logic [13:0] line_out,
    input wire logic [13:0] line_oe,
    input wire logic wr_idle,
    input wire logic irq,
    input wire logic dma,
    output logic [13:0] line_in
);
    logic [7:0] mem [256];
    logic [7:0] addr = 8'h00;
    logic [7:0] drv = 8'h00;
    logic prev = 1'b0;
    logic rd_on;
    logic wr_on;
    logic [13:0] ext;
    assign rd_on = line_oe[9] && !line_out[9];
    assign wr_on = line_oe[10] && (line_out[10] != wr_idle);
    always @(posedge clk)
    begin
        // Transparent latch: the address and the strobe fall change on one edge
        if (line_oe[8] && line_out[8])
            addr <= line_out[7:0];
        if (prev && !wr_on)
            mem[addr] <= line_out[7:0];
        // Released lines other than 11 and 12 toggle every cycle outside the read strobe so stale data never looks valid
        drv <= rd_on ? mem[addr] : ~drv;
        prev <= wr_on;
    end
    assign ext = {~drv[0], dma, irq, ~drv[3:1], drv};
    assign line_in = (line_oe & line_out) | (~line_oe & ext);
endmodule : bus_periph

/* testbench/tb.sv */
// Self-checking bench for the multiplexed expansion bus controller
`timescale 1ns/100ps
module tb;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    logic HOST_REQ = 1'b0;
    mux_bus_pkg::host_req_t HOST_CMD = '0;
    logic [7:0] ALT_CS_TIMING = 8'h06;
    logic HOST_ACK;
    logic [7:0] HOST_RDATA;
    logic HOST_BUSY;
    logic [13:0] LINE_IN;
    logic [13:0] LINE_OUT;
    logic [13:0] LINE_OE;
    logic BUS_IRQ;
    logic DMA_REQ;
    logic wr_idle = 1'b1;
    logic irq = 1'b0;
    logic dma = 1'b0;
    logic last13 = 1'b0;
    logic [7:0] rd;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;
    int wr_len = 0;
    int rd_len = 0;
    int rd_oe = 0;
    int data_oe = 0;
    int tog = 0;
    int lat = 0;
    int busy_n = 0;

    muxed_expansion_bus i_muxed_expansion_bus (.CORE_CLK(CORE_CLK), .RST(RST),
        .HOST_REQ(HOST_REQ), .HOST_CMD(HOST_CMD), .ALT_CS_TIMING(ALT_CS_TIMING),
        .HOST_ACK(HOST_ACK), .HOST_RDATA(HOST_RDATA), .HOST_BUSY(HOST_BUSY),
        .LINE_IN(LINE_IN), .LINE_OUT(LINE_OUT), .LINE_OE(LINE_OE),
        .BUS_IRQ(BUS_IRQ), .DMA_REQ(DMA_REQ));
    bus_periph i_bus_periph (.clk(CORE_CLK), .line_out(LINE_OUT), .line_oe(LINE_OE),
        .wr_idle(wr_idle), .irq(irq), .dma(dma), .line_in(LINE_IN));

    initial
    begin
        forever #2 CORE_CLK = ~CORE_CLK;
    end

    // Pin activity counters, cleared by clr before each stretch of accesses or cycles whose counts are checked
    always @(posedge CORE_CLK)
    begin
        cycles++;
        if (LINE_OE[10] && LINE_OUT[10] !== wr_idle) wr_len++;
        if (LINE_OE[9] && LINE_OUT[9] === 1'b0) rd_len++;
        if (LINE_OE[9]) rd_oe++;
        if (LINE_OE[7:0] !== 8'h00) data_oe++;
        if (LINE_OUT[13] !== last13) tog++;
        last13 = LINE_OUT[13];
        if (cycles == 20000)
        begin
            error_cnt++;
            results();
        end
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic host(input logic we, input logic [31:0] a, input logic [7:0] d);
        int n;
        @(posedge CORE_CLK);
        HOST_REQ <= 1'b1;
        HOST_CMD <= {we, a, d};
        @(posedge CORE_CLK);
        HOST_REQ <= 1'b0;
        n = 0;
        busy_n = 0;
        do
        begin
            @(negedge CORE_CLK);
            n++;
            if (HOST_BUSY === 1'b1) busy_n++;
        end
        while (HOST_ACK !== 1'b1 && n < 200);
        if (n >= 200) error_cnt++;
        lat = n;
        rd = HOST_RDATA;
    endtask : host

    task automatic clr();
        @(negedge CORE_CLK);
        wr_len = 0;
        rd_len = 0;
        rd_oe = 0;
        data_oe = 0;
        tog = 0;
    endtask : clr

    task automatic t_reset();
        repeat (2) @(negedge CORE_CLK);
        chk("strobe idle", 16'h0007, 16'(LINE_OUT[10:8]));
        chk("line oe", 16'h0000, 16'(LINE_OE));
        $display("end reset");
    endtask : t_reset

    task automatic t_write_read();
        host(1'b1, mux_bus_pkg::DIR_LOW_ADDR, 8'hFF);
        host(1'b1, mux_bus_pkg::DIR_HIGH_ADDR, 8'h07);
        host(1'b0, mux_bus_pkg::DIR_LOW_ADDR, 8'h00);
        chk("dir readback", 16'h00FF, 16'(rd));
        chk("reg ack", 16'd1, 16'(lat));
        chk("reg busy", 16'd0, 16'(busy_n));
        host(1'b1, mux_bus_pkg::BUS_ADDR_REG_ADDR, 8'h5A);
        clr();
        host(1'b1, mux_bus_pkg::WINDOW_ADDR, 8'hC3);
        chk("cycle ack", 16'd22, 16'(lat));
        chk("cycle busy", 16'd21, 16'(busy_n));
        chk("write strobe", 16'd14, 16'(wr_len));
        chk("read strobe", 16'd0, 16'(rd_len));
        chk("peer byte", 16'h00C3, 16'(i_bus_periph.mem[8'h5A]));
        clr();
        host(1'b0, mux_bus_pkg::WINDOW_ADDR, 8'h00);
        chk("read data", 16'h00C3, 16'(rd));
        chk("read strobe", 16'd14, 16'(rd_len));
        chk("write strobe", 16'd0, 16'(wr_len));
        $display("end write_read");
    endtask : t_write_read

    task automatic t_seq();
        host(1'b1, mux_bus_pkg::BUS_ADDR_REG_ADDR, 8'hFF);
        host(1'b1, mux_bus_pkg::SEQ_ADDR, 8'h11);
        host(1'b1, mux_bus_pkg::SEQ_ADDR, 8'h22);
        chk("seq byte ff", 16'h0011, 16'(i_bus_periph.mem[8'hFF]));
        chk("seq byte 00", 16'h0022, 16'(i_bus_periph.mem[8'h00]));
        host(1'b1, mux_bus_pkg::BUS_ADDR_REG_ADDR, 8'hFF);
        host(1'b0, mux_bus_pkg::SEQ_ADDR, 8'h00);
        chk("seq read ff", 16'h0011, 16'(rd));
        host(1'b0, mux_bus_pkg::SEQ_ADDR, 8'h00);
        chk("seq read 00", 16'h0022, 16'(rd));
        host(1'b0, mux_bus_pkg::BUS_ADDR_REG_ADDR, 8'h00);
        chk("addr after wrap", 16'h0001, 16'(rd));
        $display("end seq");
    endtask : t_seq

    task automatic t_alt_pol();
        clr();
        host(1'b1, mux_bus_pkg::ALT_ADDR, 8'h77);
        chk("alt strobe", 16'd6, 16'(wr_len));
        chk("alt ack", 16'd14, 16'(lat));
        chk("alt byte", 16'h0077, 16'(i_bus_periph.mem[8'h01]));
        host(1'b1, mux_bus_pkg::LEVEL_STROBE_ADDR, 8'h03);
        @(posedge CORE_CLK);
        wr_idle <= 1'b0;
        clr();
        host(1'b1, mux_bus_pkg::WINDOW_ADDR, 8'h5E);
        chk("inverted strobe", 16'd14, 16'(wr_len));
        chk("write idle", 16'h0000, 16'(LINE_OUT[10]));
        chk("inv byte", 16'h005E, 16'(i_bus_periph.mem[8'h01]));
        host(1'b1, mux_bus_pkg::LEVEL_STROBE_ADDR, 8'h07);
        @(posedge CORE_CLK);
        wr_idle <= 1'b1;
        $display("end alt_pol");
    endtask : t_alt_pol

    task automatic t_inputs();
        host(1'b1, mux_bus_pkg::DIR_HIGH_ADDR, 8'h05);
        host(1'b1, mux_bus_pkg::DIR_LOW_ADDR, 8'h00);
        clr();
        host(1'b0, mux_bus_pkg::WINDOW_ADDR, 8'h00);
        host(1'b1, mux_bus_pkg::WINDOW_ADDR, 8'h99);
        chk("read line oe", 16'd0, 16'(rd_oe));
        chk("data line oe", 16'd0, 16'(data_oe));
        chk("write strobe", 16'd14, 16'(wr_len));
        $display("end inputs");
    endtask : t_inputs

    task automatic t_feat();
        @(posedge CORE_CLK);
        irq <= 1'b1;
        dma <= 1'b1;
        host(1'b1, mux_bus_pkg::FEATURE_ADDR, 8'h06);
        repeat (5) @(negedge CORE_CLK);
        chk("irq on", 16'h0001, 16'(BUS_IRQ));
        chk("dma on", 16'h0001, 16'(DMA_REQ));
        irq <= 1'b0;
        repeat (5) @(negedge CORE_CLK);
        chk("irq low", 16'h0000, 16'(BUS_IRQ));
        irq <= 1'b1;
        host(1'b1, mux_bus_pkg::FEATURE_ADDR, 8'h00);
        repeat (5) @(negedge CORE_CLK);
        chk("irq gated", 16'h0000, 16'(BUS_IRQ));
        chk("dma gated", 16'h0000, 16'(DMA_REQ));
        host(1'b1, mux_bus_pkg::DIR_HIGH_ADDR, 8'h20);
        host(1'b1, mux_bus_pkg::FEATURE_ADDR, 8'h08);
        repeat (10) @(negedge CORE_CLK);
        clr();
        repeat (1000) @(negedge CORE_CLK);
        // Expected edges: 2 * 14.7456 MHz * 1000 cycles / 250 MHz, about 117.96
        chk("clock edges", 16'd1, 16'(tog >= 117 && tog <= 118));
        host(1'b1, mux_bus_pkg::FEATURE_ADDR, 8'h00);
        repeat (5) @(negedge CORE_CLK);
        clr();
        repeat (100) @(negedge CORE_CLK);
        chk("clock stopped", 16'd0, 16'(tog));
        $display("end feat");
    endtask : t_feat

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    initial
    begin
        repeat (12) @(posedge CORE_CLK);
        RST <= 1'b0;
        t_reset();
        t_write_read();
        t_seq();
        t_alt_pol();
        t_inputs();
        t_feat();
        results();
    end
endmodule : tb
